// ===== common/ddl_pkg.sv
package ddl_pkg;
    localparam int WORD_W     = 16;
    localparam int BUS_W      = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W      = $clog2(FIFO_DEPTH + 1);
    localparam int PARCELS    = WORD_W / BUS_W;
    localparam int PCNT_W     = 3;

    localparam int CLK_PERIOD_NS  = 100;
    localparam int LINK_PERIOD_NS = 800;
    localparam int LINK_CYC       = LINK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LINK_HALF      = LINK_CYC / 2;
    localparam int CAPTURE_DLY    = LINK_HALF / 2;
    localparam int PH_W           = 3;
    localparam logic [PH_W-1:0] PH_LAST     = PH_W'(LINK_CYC - 1);
    localparam logic [PH_W-1:0] PH_HALF_END = PH_W'(LINK_HALF - 1);
    localparam logic [PH_W-1:0] PH_CAPTURE  = PH_W'(CAPTURE_DLY);

    localparam logic [2:0] LOCK_EDGES   = 3'h4;
    localparam int         AFULL_MARGIN = 4;
    localparam logic [CNT_W-1:0] AFULL_RESET =
        CNT_W'(FIFO_DEPTH - AFULL_MARGIN);

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
    localparam logic [ADDR_W-1:0] AFULL_OFS   = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] RXWORDS_OFS = 8'h0C;
    localparam int CTRL_TXEN_BIT   = 0;
    localparam logic CTRL_TXEN_RESET = 1'b1;
    localparam int ST_LOCK_BIT     = 0;
    localparam int ST_FARFULL_BIT  = 1;
    localparam int ST_RXRST_BIT    = 2;
    localparam int ST_TXBUSY_BIT   = 3;
    localparam int ST_TXCNT_LSB    = 8;
    localparam int ST_RXCNT_LSB    = 16;

    typedef struct packed {
        logic              clk;
        logic              flag;
        logic [BUS_W-1:0]  data;
    } ddl_link_t;
endpackage : ddl_pkg

// ===== rtl/ddl_fifo.sv
module ddl_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16,
    parameter int CW    = 5
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    input  wire logic          clr,
    input  wire logic          push,
    input  wire logic [W-1:0]  push_data,
    input  wire logic          pop,
    output logic               full,
    output logic               empty,
    output logic [W-1:0]       rd_data,
    output logic [CW-1:0]      count
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic          do_push;
    logic          do_pop;
    logic [CW-1:0] count_next;

    // Full and empty are registered so the user sees clean flags.
    assign do_push = push & ~full & ~clr;
    assign do_pop  = pop & ~empty & ~clr;

    always_comb begin
        count_next = count;
        if (clr) begin
            count_next = '0;
        end else if (do_push && !do_pop) begin
            count_next = count + CW'(1);
        end else if (do_pop && !do_push) begin
            count_next = count - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (clk_en && do_push) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count      <= '0;
            full       <= 1'b0;
            empty      <= 1'b1;
            rd_data    <= '0;
        end else if (clk_en) begin
            if (clr) begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
            end else begin
                if (do_push) begin
                    wr_ptr_reg <= wr_ptr_reg + AW'(1);
                end
                if (do_pop) begin
                    rd_ptr_reg <= rd_ptr_reg + AW'(1);
                    rd_data    <= mem[rd_ptr_reg];
                end
            end
            count <= count_next;
            full  <= (count_next == CW'(DEPTH));
            empty <= (count_next == '0);
        end
    end
endmodule : ddl_fifo

// ===== rtl/ddl_channel.sv
// One chip's end of two one-way channels: a transmitter for the outgoing
// channel and a receiver for the incoming one.
module ddl_channel
    import ddl_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clk_en,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               tx_wr_en,
    input  wire logic [WORD_W-1:0]  tx_wr_data,
    output logic                    tx_full,
    input  wire logic               rx_rd_en,
    output logic [WORD_W-1:0]       rx_rd_data,
    output logic                    rx_rd_valid,
    output logic                    rx_empty,
    output ddl_link_t               tx_link,
    output logic                    receiver_reset_link,
    input  wire logic               receiver_almost_full,
    input  wire logic               link_clock_feedback_in,
    input  wire ddl_link_t          rx_link,
    input  wire logic               rx_reset_link_in,
    output logic                    rx_almost_full
);
    logic [2:0]        fb_sync;
    logic [1:0]        afull_sync;
    logic [1:0]        rxrst_sync;
    ddl_link_t         rxl_s1;
    ddl_link_t         rxl_s2;
    logic              rclk_prev;

    logic              tx_enable_reg;
    logic [CNT_W-1:0]  afull_level_reg;
    logic [31:0]       rx_words_reg;
    logic [31:0]       rd_word;
    logic              rd_bad;
    logic              setup;
    logic              access_done;

    logic [PH_W-1:0]   ph_reg;
    logic [2:0]        lock_cnt_reg;
    logic              lock_reg;
    logic              pop_pend_reg;
    logic              stage_valid_reg;
    logic [WORD_W-1:0] sh_reg;
    logic [PCNT_W-1:0] left_reg;
    logic              tx_pop;
    logic              tx_start;
    logic              tx_empty;
    logic [WORD_W-1:0] tx_rd_data;
    logic [CNT_W-1:0]  tx_count;

    logic [PH_W-1:0]   cap_cnt_reg;
    logic              cap_arm_reg;
    logic              cap_ph1_reg;
    logic              got0_reg;
    logic [WORD_W-1:0] asm_reg;
    logic [PCNT_W-1:0] asm_cnt_reg;
    logic              push_reg;
    logic [WORD_W-1:0] push_data_reg;
    logic              rise;
    logic              fall;
    logic              fire;
    logic              take;
    logic              rx_clr;
    logic              rx_pop;
    logic              rx_full;
    logic [CNT_W-1:0]  rx_count;

    // Every pin from the far chip passes two flops before any logic sees it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_sync    <= '0;
            afull_sync <= 2'h3;
            rxrst_sync <= 2'h3;
            rxl_s1     <= '0;
            rxl_s2     <= '0;
            rclk_prev  <= 1'b0;
        end else if (clk_en) begin
            fb_sync    <= {fb_sync[1:0], link_clock_feedback_in};
            afull_sync <= {afull_sync[0], receiver_almost_full};
            rxrst_sync <= {rxrst_sync[0], rx_reset_link_in};
            rxl_s1     <= rx_link;
            rxl_s2     <= rxl_s1;
            rclk_prev  <= rxl_s2.clk;
        end
    end

    // Register bus: zero wait states, pready rises in the access phase.
    assign setup       = psel & ~penable;
    assign access_done = psel & penable & pready;

    always_comb begin
        rd_word = '0;
        rd_bad  = 1'b0;
        case (paddr)
            CTRL_OFS:    rd_word[CTRL_TXEN_BIT] = tx_enable_reg;
            AFULL_OFS:   rd_word[CNT_W-1:0] = afull_level_reg;
            STATUS_OFS: begin
                rd_word[ST_LOCK_BIT]    = lock_reg;
                rd_word[ST_FARFULL_BIT] = afull_sync[1];
                rd_word[ST_RXRST_BIT]   = rxrst_sync[1];
                rd_word[ST_TXBUSY_BIT]  = (left_reg != '0);
                rd_word[ST_TXCNT_LSB +: CNT_W] = tx_count;
                rd_word[ST_RXCNT_LSB +: CNT_W] = rx_count;
            end
            RXWORDS_OFS: rd_word = rx_words_reg;
            default:     rd_bad  = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (clk_en) begin
            pready <= setup;
            if (setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_word;
                pslverr <= rd_bad;
            end else if (access_done) begin
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_enable_reg   <= CTRL_TXEN_RESET;
            afull_level_reg <= AFULL_RESET;
        end else if (clk_en && access_done && pwrite && !pslverr) begin
            if (paddr == CTRL_OFS) begin
                tx_enable_reg <= pwdata[CTRL_TXEN_BIT];
            end
            if (paddr == AFULL_OFS) begin
                afull_level_reg <= pwdata[CNT_W-1:0];
            end
        end
    end

    ddl_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH),
        .CW    (CNT_W)
    ) u_tx_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .clk_en    (clk_en),
        .clr       (1'b0),
        .push      (tx_wr_en),
        .push_data (tx_wr_data),
        .pop       (tx_pop),
        .full      (tx_full),
        .empty     (tx_empty),
        .rd_data   (tx_rd_data),
        .count     (tx_count)
    );

    // The phase divider is the clock loop; pclk is the only clock used.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_reg       <= '0;
            lock_cnt_reg <= '0;
            lock_reg     <= 1'b0;
        end else if (clk_en) begin
            ph_reg <= (ph_reg == PH_LAST) ? '0 : ph_reg + PH_W'(1);
            if (fb_sync[1] && !fb_sync[2] && !lock_reg) begin
                lock_cnt_reg <= lock_cnt_reg + 3'h1;
                lock_reg     <= (lock_cnt_reg == LOCK_EDGES - 3'h1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receiver_reset_link <= 1'b1;
        end else if (clk_en) begin
            receiver_reset_link <= ~lock_reg;
        end
    end

    // A word already started is finished even if almost-full rises.
    assign tx_pop   = ~tx_empty & ~stage_valid_reg & ~pop_pend_reg;
    assign tx_start = stage_valid_reg & lock_reg & ~afull_sync[1]
                    & tx_enable_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_pend_reg    <= 1'b0;
            stage_valid_reg <= 1'b0;
            sh_reg          <= '0;
            left_reg        <= '0;
            tx_link         <= '0;
        end else if (clk_en) begin
            pop_pend_reg <= tx_pop;
            if (pop_pend_reg) begin
                stage_valid_reg <= 1'b1;
            end
            if (ph_reg == PH_LAST) begin
                tx_link.clk <= 1'b1;
                if (left_reg != '0) begin
                    tx_link.data <= sh_reg[BUS_W-1:0];
                    sh_reg       <= sh_reg >> BUS_W;
                    left_reg     <= left_reg - PCNT_W'(1);
                    tx_link.flag <= 1'b1;
                end else if (tx_start) begin
                    tx_link.data    <= tx_rd_data[BUS_W-1:0];
                    sh_reg          <= tx_rd_data >> BUS_W;
                    left_reg        <= PCNT_W'(PARCELS - 1);
                    tx_link.flag    <= 1'b1;
                    stage_valid_reg <= 1'b0;
                end else begin
                    tx_link.flag <= 1'b0;
                end
            end else if (ph_reg == PH_HALF_END) begin
                tx_link.clk  <= 1'b0;
                tx_link.flag <= 1'b0;
                if (tx_link.flag) begin
                    tx_link.data <= sh_reg[BUS_W-1:0];
                    sh_reg       <= sh_reg >> BUS_W;
                    left_reg     <= left_reg - PCNT_W'(1);
                end
            end
        end
    end

    // Receiver: the forwarded clock's edges time the capture, mid-phase.
    assign rise   = rxl_s2.clk & ~rclk_prev;
    assign fall   = ~rxl_s2.clk & rclk_prev;
    assign fire   = cap_arm_reg & (cap_cnt_reg == PH_CAPTURE);
    assign take   = fire & (cap_ph1_reg ? got0_reg : rxl_s2.flag);
    assign rx_clr = rxrst_sync[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_cnt_reg <= '0;
            cap_arm_reg <= 1'b0;
            cap_ph1_reg <= 1'b0;
        end else if (clk_en) begin
            if (rise || fall) begin
                cap_cnt_reg <= PH_W'(1);
                cap_arm_reg <= 1'b1;
                cap_ph1_reg <= fall;
            end else if (fire) begin
                cap_arm_reg <= 1'b0;
            end else if (cap_arm_reg) begin
                cap_cnt_reg <= cap_cnt_reg + PH_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got0_reg      <= 1'b0;
            asm_reg       <= '0;
            asm_cnt_reg   <= '0;
            push_reg      <= 1'b0;
            push_data_reg <= '0;
        end else if (clk_en) begin
            push_reg <= 1'b0;
            if (rx_clr) begin
                got0_reg    <= 1'b0;
                asm_cnt_reg <= '0;
            end else begin
                if (fire) begin
                    got0_reg <= ~cap_ph1_reg & rxl_s2.flag;
                end
                if (take) begin
                    asm_reg <= {rxl_s2.data, asm_reg[WORD_W-1:BUS_W]};
                    if (asm_cnt_reg == PCNT_W'(PARCELS - 1)) begin
                        asm_cnt_reg   <= '0;
                        push_reg      <= 1'b1;
                        push_data_reg <= {rxl_s2.data,
                                          asm_reg[WORD_W-1:BUS_W]};
                    end else begin
                        asm_cnt_reg <= asm_cnt_reg + PCNT_W'(1);
                    end
                end
            end
        end
    end

    assign rx_pop = rx_rd_en & ~rx_empty;

    ddl_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH),
        .CW    (CNT_W)
    ) u_rx_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .clk_en    (clk_en),
        .clr       (rx_clr),
        .push      (push_reg),
        .push_data (push_data_reg),
        .pop       (rx_pop),
        .full      (rx_full),
        .empty     (rx_empty),
        .rd_data   (rx_rd_data),
        .count     (rx_count)
    );

    // Raising almost-full at a margin below depth covers the sync delay
    // and the word still on the wire at the far end.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_almost_full <= 1'b1;
            rx_rd_valid    <= 1'b0;
            rx_words_reg   <= '0;
        end else if (clk_en) begin
            rx_almost_full <= rx_clr | rx_full
                            | (rx_count >= afull_level_reg);
            rx_rd_valid    <= rx_pop;
            if (rx_clr) begin
                rx_words_reg <= '0;
            end else if (push_reg) begin
                rx_words_reg <= rx_words_reg + 32'h0000_0001;
            end
        end
    end
endmodule : ddl_channel

// ===== verif/ddl_channel_sva.sv
module ddl_channel_sva
    import ddl_pkg::*;
(
    input wire logic      pclk,
    input wire logic      presetn,
    input wire ddl_link_t tx_link,
    input wire logic      tx_full,
    input wire logic      receiver_reset_link,
    input wire logic      receiver_almost_full,
    input wire logic      link_clock_feedback_in,
    input wire logic      rx_rd_en,
    input wire logic      rx_rd_valid,
    input wire logic      rx_empty,
    input wire logic      rx_reset_link_in,
    input wire logic      rx_almost_full
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [2:0] fb_cnt;
    logic       second_half;

    // Raw feedback edges are counted; the design syncs them first, so its
    // own count can only lag this one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_cnt <= 3'h0;
        end else if ($rose(link_clock_feedback_in) && fb_cnt != 3'h7) begin
            fb_cnt <= fb_cnt + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_half <= 1'b0;
        end else if ($rose(tx_link.flag)) begin
            second_half <= !second_half;
        end
    end

    sequence s_flag_ph0;
        tx_link.flag[*4] ##1 !tx_link.flag;
    endsequence
    sequence s_clk_cycle;
        tx_link.clk[*4] ##1 !tx_link.clk[*4] ##1 tx_link.clk;
    endsequence
    sequence s_far_full;
        receiver_almost_full[*5] ##1 $rose(tx_link.flag);
    endsequence

    property p_ph1;
        !tx_link.clk |-> !tx_link.flag;
    endproperty
    property p_ph0;
        $rose(tx_link.flag) |-> $rose(tx_link.clk) ##0 s_flag_ph0;
    endproperty
    property p_clk;
        $rose(tx_link.clk) |-> s_clk_cycle;
    endproperty
    property p_flow;
        s_far_full |-> second_half;
    endproperty
    property p_lock;
        $fell(receiver_reset_link) |-> fb_cnt >= 3'h4;
    endproperty
    property p_rst;
        $rose(presetn) |-> receiver_reset_link && rx_empty && !tx_full
            && rx_almost_full && !tx_link.flag;
    endproperty
    property p_rd;
        rx_rd_en && !rx_empty |=> rx_rd_valid;
    endproperty
    property p_rxr;
        rx_reset_link_in[*4] |=> rx_almost_full;
    endproperty

    a_ph1: assert property (p_ph1)
        else $error("flag high in phase 1");
    a_ph0: assert property (p_ph0)
        else $error("flag not held through phase 0");
    a_clk: assert property (p_clk)
        else $error("link clock period wrong");
    a_flow: assert property (p_flow)
        else $error("word started while far end full");
    a_lock: assert property (p_lock)
        else $error("receiver reset released before lock");
    a_rst: assert property (p_rst)
        else $error("wrong state after reset");
    a_rd: assert property (p_rd)
        else $error("read not answered");
    a_rxr: assert property (p_rxr)
        else $error("almost full low in receiver reset");
endmodule : ddl_channel_sva

bind ddl_channel ddl_channel_sva i_ddl_channel_sva (
    .pclk(pclk), .presetn(presetn), .tx_link(tx_link), .tx_full(tx_full),
    .receiver_reset_link(receiver_reset_link),
    .receiver_almost_full(receiver_almost_full),
    .link_clock_feedback_in(link_clock_feedback_in),
    .rx_rd_en(rx_rd_en), .rx_rd_valid(rx_rd_valid), .rx_empty(rx_empty),
    .rx_reset_link_in(rx_reset_link_in), .rx_almost_full(rx_almost_full)
);

// ===== verif/ddl_far_end.sv
module ddl_far_end
    import ddl_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire ddl_link_t link_in,
    input  wire logic      rcv_reset,
    input  wire logic      stall,
    input  wire logic      near_afull,
    output ddl_link_t      link_out,
    output logic           afull
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [WORD_W-1:0] got [$];
    logic [WORD_W-1:0] shift_w;
    logic [2:0]        ph;
    logic [1:0]        n_par;
    logic              clk_q;
    logic              carry;

    // Held full while in reset so the sender waits for a ready receiver.
    assign afull = rcv_reset | stall | near_afull;

    // One register stage stands for wire flight time; idle data in phase 0
    // (clock high, flag low) is inverted so a stale parcel can never pass for a fresh one.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {clk_q, carry, n_par, ph} <= '0;
            link_out <= '0;
        end else begin
            clk_q <= link_in.clk;
            ph <= (link_in.clk && !clk_q) ? 3'h1 : ph + 3'h1;
            if (ph == 3'h2) carry <= link_in.flag;
            if ((ph == 3'h2 && link_in.flag) || (ph == 3'h6 && carry)) begin
                shift_w <= {link_in.data, shift_w[WORD_W-1:BUS_W]};
                n_par <= n_par + 2'h1;
                if (n_par == 2'(PARCELS - 1))
                    got.push_back({link_in.data, shift_w[WORD_W-1:BUS_W]});
            end
            link_out <= link_in;
            if (link_in.clk && !link_in.flag) link_out.data <= ~link_in.data;
        end
    end
endmodule : ddl_far_end

// ===== verif/ddl_channel_test.sv
module ddl_channel_test
    import ddl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              pclk, presetn, psel, penable, pwrite, pready;
    logic              pslverr, err_q, tx_wr_en, tx_full, rx_rd_en;
    logic              rx_rd_valid, rx_empty, receiver_reset_link;
    logic              rx_almost_full, far_afull, stall;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd_q;
    logic [WORD_W-1:0] tx_wr_data, rx_rd_data;
    logic [WORD_W-1:0] exp_q [$];
    ddl_link_t         tx_link, rx_link;
    int                mismatches, checks;

    ddl_channel i_ddl_channel (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_wr_en(tx_wr_en), .tx_wr_data(tx_wr_data), .tx_full(tx_full),
        .rx_rd_en(rx_rd_en), .rx_rd_data(rx_rd_data),
        .rx_rd_valid(rx_rd_valid), .rx_empty(rx_empty), .tx_link(tx_link),
        .receiver_reset_link(receiver_reset_link),
        .receiver_almost_full(far_afull),
        .link_clock_feedback_in(tx_link.clk),
        .rx_link(rx_link), .rx_reset_link_in(receiver_reset_link),
        .rx_almost_full(rx_almost_full)
    );

    ddl_far_end i_ddl_far_end (
        .pclk(pclk), .presetn(presetn), .link_in(tx_link),
        .rcv_reset(receiver_reset_link), .stall(stall),
        .near_afull(rx_almost_full), .link_out(rx_link), .afull(far_afull)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic [WORD_W-1:0] word(input int i);
        return {4'(i + 3), 4'(i + 2), 4'(i + 1), 4'(i)};
    endfunction : word

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic give_up(input string what);
        mismatches++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        stop_test();
    endtask : give_up

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) give_up("apb");
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rx_pop(input logic [WORD_W-1:0] exp);
        int n;
        for (n = 0; n < 400 && rx_empty !== 1'b0; n++) @(posedge pclk);
        if (rx_empty !== 1'b0) give_up("rx wait");
        rx_rd_en <= 1'b1;
        @(posedge pclk);
        rx_rd_en <= 1'b0;
        @(negedge pclk);
        check("rx valid", 1, rx_rd_valid);
        check("rx word", exp, rx_rd_data);
        @(posedge pclk);
    endtask : rx_pop

    initial begin
        {presetn, psel, penable, pwrite, tx_wr_en, rx_rd_en, stall} = '0;
        {paddr, pwdata, tx_wr_data} = '0;
        mismatches = 0;
        checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("rcv reset", 1, receiver_reset_link);
        apb(1'b0, CTRL_OFS, 0);
        check("ctrl", 32'(CTRL_TXEN_RESET), rd_q);
        apb(1'b0, AFULL_OFS, 0);
        check("afull level", 32'(AFULL_RESET), rd_q);
        // A lower level still leaves room for the word already in flight.
        apb(1'b1, AFULL_OFS, 32'h0000_000A);
        apb(1'b0, AFULL_OFS, 0);
        check("afull write", 32'h0000_000A, rd_q);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        check("unmapped err", 1, err_q);
        apb(1'b0, 8'h40, 0);
        check("unmapped data", 0, rd_q);
        for (int i = 0; i < 60; i++) begin
            apb(1'b0, STATUS_OFS, 0);
            if (rd_q[ST_LOCK_BIT] === 1'b1) break;
        end
        if (rd_q[ST_LOCK_BIT] !== 1'b1) give_up("lock");
        check("rcv reset", 0, receiver_reset_link);
        // Far end stalls first, so the whole buffer fills before any word
        // leaves and the refused writes are seen.
        stall <= 1'b1;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < FIFO_DEPTH + 4; i++) begin
            tx_wr_en <= 1'b1;
            tx_wr_data <= word(i);
            @(negedge pclk);
            if (tx_full === 1'b0) exp_q.push_back(word(i));
            @(posedge pclk);
        end
        tx_wr_en <= 1'b0;
        check("tx full", 1, tx_full);
        check("accepted", 1, 32'(exp_q.size() >= FIFO_DEPTH));
        check("far idle", 0, i_ddl_far_end.got.size());
        stall <= 1'b0;
        for (int i = 0; i < 1000 && rx_almost_full !== 1'b1; i++)
            @(posedge pclk);
        check("rx afull", 1, rx_almost_full);
        if (rx_almost_full !== 1'b1) stop_test();
        foreach (exp_q[i]) rx_pop(exp_q[i]);
        check("far count", exp_q.size(), i_ddl_far_end.got.size());
        foreach (exp_q[i])
            check("far word", exp_q[i], i_ddl_far_end.got[i]);
        apb(1'b0, RXWORDS_OFS, 0);
        check("rx words", exp_q.size(), rd_q);
        tx_wr_en <= 1'b1;
        @(posedge pclk);
        tx_wr_en <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check("rcv reset", 1, receiver_reset_link);
        check("link idle", 0, 32'(tx_link));
        check("rx empty", 1, rx_empty);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (60) @(posedge pclk);
        stop_test();
    end
endmodule : ddl_channel_test
